// ===== common/hielv_consts.vh
`ifndef HIELV_CONSTS_VH
`define HIELV_CONSTS_VH
// ===========================================================
// register byte offsets
`define HIELV_OFF_STATUS 8'h58
`define HIELV_OFF_ENABLE 8'h5c
`define HIELV_OFF_LEVEL 8'h68
`define HIELV_OFF_EVT_STS 8'h70
`define HIELV_OFF_EVT_CLR 8'h74
`define HIELV_OFF_EVT_EN 8'h78
// ===========================================================
// enable register layout
`define HIELV_EN_WMASK 32'hffbbfff8
`define HIELV_EN_RSVD_ZERO 32'h00000820
`define HIELV_EN_RESET 32'h00000000
`define HIELV_BIT_SW 31
`define HIELV_BIT_TX_DATA_SPACE_FLAG 9
`define HIELV_BIT_TX_STATUS_LEVEL_FLAG 7
`define HIELV_BIT_RX_STATUS_LEVEL_FLAG 3
`define HIELV_LEVEL_FLAGS 32'h00000288
// ===========================================================
// level register layout
`define HIELV_LEVEL_RESET 32'h48000000
`define HIELV_TXD_HI 31
`define HIELV_TXD_LO 24
`define HIELV_TXS_HI 23
`define HIELV_TXS_LO 16
`define HIELV_RXS_HI 7
`define HIELV_RXS_LO 0
// ===========================================================
// block event bits
`define HIELV_EVT_TX_DATA_SPACE_FLAG 0
`define HIELV_EVT_TX_STATUS_LEVEL_FLAG 1
`define HIELV_EVT_RX_STATUS_LEVEL_FLAG 2
`define HIELV_EVT_W 3
`endif

// ===== design/hielv_top.v
`timescale 1ns/100ps
`include "hielv_consts.vh"

// What this block does
// R1: set enable bit admits source to irq
// R2: status flags report regardless of enable, except software
// R3: enable register 32 bits mirroring status layout
// R4: writable enable bits reset to zero
// R5: top byte enable positions 31 to 28
// R6: phy, tx/rx stopped enables at 27-24
// R7: enables at 23,21,20,19,17; 22,18 reserved
// R8: enables at bits 16 to 12
// R9: enables at 10,9,8,7,6,4,3
// R10: host writes zero to bits 11, 5
// R11: enable bits 2:0 read-only reserved
// R12: tx data threshold bits 31:24, reset 48h
// R13: flag when tx free space exceeds threshold
// R14: tx status threshold 23:16, occupancy compare
// R15: rx status threshold 7:0, occupancy compare
// R16: host writes zero to level bits 15:8
// R17: status flags clear on write one
// R18: irq high while flag and enable set
module hielv_top #(
  parameter CNT_W = 8
) (
  input wire SYS_CLK,
  input wire SYS_RST,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  input wire [31:0] SRC_EVENTS,
  input wire [CNT_W-1:0] TX_DATA_FREE,
  input wire [CNT_W-1:0] TX_STATUS_USED,
  input wire [CNT_W-1:0] RX_STATUS_USED,
  output reg IRQ,
  output reg EVT_IRQ
);

  // ===========================================================
  // helpers
  function [31:0] lane_mask;
    input [3:0] sel;
    begin
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  function above;
    input [CNT_W-1:0] level;
    input [7:0] thr;
    begin
      above = ({{8{1'b0}}, level} > {{CNT_W{1'b0}}, thr});
    end
  endfunction

  // ===========================================================
  // bus decode
  wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wr = req & WB_WE_I;
  wire [31:0] bm = lane_mask(WB_SEL_I);
  wire wr_sts = wr & (WB_ADR_I == `HIELV_OFF_STATUS);
  wire wr_en = wr & (WB_ADR_I == `HIELV_OFF_ENABLE);
  wire wr_lvl = wr & (WB_ADR_I == `HIELV_OFF_LEVEL);
  wire wr_eclr = wr & (WB_ADR_I == `HIELV_OFF_EVT_CLR);
  wire wr_een = wr & (WB_ADR_I == `HIELV_OFF_EVT_EN);

  reg [31:0] enable_q;
  reg [31:0] level_q;
  reg [31:0] status_q;
  reg [`HIELV_EVT_W-1:0] evt_sts_q;
  reg [`HIELV_EVT_W-1:0] evt_en_q;
  reg [`HIELV_EVT_W-1:0] lvl_prev_q;

  // ===========================================================
  // level comparisons
  wire tx_data_space_flag_lvl = above(TX_DATA_FREE, level_q[`HIELV_TXD_HI:`HIELV_TXD_LO]); // R13
  wire tx_status_level_flag_lvl = above(TX_STATUS_USED, level_q[`HIELV_TXS_HI:`HIELV_TXS_LO]); // R14
  wire rx_status_level_flag_lvl = above(RX_STATUS_USED, level_q[`HIELV_RXS_HI:`HIELV_RXS_LO]); // R15
  wire [`HIELV_EVT_W-1:0] lvl_now = {rx_status_level_flag_lvl, tx_status_level_flag_lvl, tx_data_space_flag_lvl};

  // level flags fire as sources alongside the external events
  reg [31:0] src;
  always @* begin
    src = SRC_EVENTS & ~`HIELV_LEVEL_FLAGS;
    src[`HIELV_BIT_TX_DATA_SPACE_FLAG] = tx_data_space_flag_lvl;
    src[`HIELV_BIT_TX_STATUS_LEVEL_FLAG] = tx_status_level_flag_lvl;
    src[`HIELV_BIT_RX_STATUS_LEVEL_FLAG] = rx_status_level_flag_lvl;
    // software source only reports while it is enabled
    src[`HIELV_BIT_SW] = SRC_EVENTS[`HIELV_BIT_SW] & enable_q[`HIELV_BIT_SW]; // R2
    // reserved status positions never report, even though enable 11 and 5 store
    src = src & `HIELV_EN_WMASK & ~`HIELV_EN_RSVD_ZERO; // R3
  end

  // ===========================================================
  // registers
  wire [31:0] sts_clr = wr_sts ? (WB_DAT_I & bm) : 32'h00000000;
  wire [`HIELV_EVT_W-1:0] lvl_rise = lvl_now & ~lvl_prev_q;
  wire [`HIELV_EVT_W-1:0] eclr = wr_eclr ? WB_DAT_I[`HIELV_EVT_W-1:0] & bm[`HIELV_EVT_W-1:0]
    : {`HIELV_EVT_W{1'b0}};

  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      enable_q <= `HIELV_EN_RESET; // R4
      level_q <= `HIELV_LEVEL_RESET; // R12
      status_q <= 32'h00000000;
      evt_sts_q <= {`HIELV_EVT_W{1'b0}};
      evt_en_q <= {`HIELV_EVT_W{1'b0}};
      lvl_prev_q <= {`HIELV_EVT_W{1'b0}};
    end else begin
      lvl_prev_q <= lvl_now;
      // set wins over a write-one clear in the same cycle
      status_q <= (status_q & ~sts_clr) | src; // R17 R2
      evt_sts_q <= (evt_sts_q & ~eclr) | lvl_rise;
      if (wr_en)
        // writable reserved bits 11 and 5 store what is written, zero is expected
        enable_q <= (enable_q & ~(bm & `HIELV_EN_WMASK)) | (WB_DAT_I & bm & `HIELV_EN_WMASK); // R5 R6 R7 R8 R9 R11 R10
      if (wr_lvl)
        level_q <= (level_q & ~bm) | (WB_DAT_I & bm); // R12 R14 R15 R16
      if (wr_een)
        evt_en_q <= (evt_en_q & ~bm[`HIELV_EVT_W-1:0]) | (WB_DAT_I[`HIELV_EVT_W-1:0]
          & bm[`HIELV_EVT_W-1:0]);
    end
  end

  // ===========================================================
  // read data and ack: registered, one cycle after the request
  reg [31:0] rd;
  always @* begin
    case (WB_ADR_I)
      `HIELV_OFF_STATUS: rd = status_q;
      `HIELV_OFF_ENABLE: rd = enable_q & `HIELV_EN_WMASK; // R11
      `HIELV_OFF_LEVEL: rd = level_q;
      `HIELV_OFF_EVT_STS: rd = {{(32-`HIELV_EVT_W){1'b0}}, evt_sts_q};
      `HIELV_OFF_EVT_EN: rd = {{(32-`HIELV_EVT_W){1'b0}}, evt_en_q};
      default: rd = 32'h00000000;
    endcase
  end

  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      IRQ <= 1'b0;
      EVT_IRQ <= 1'b0;
    end else begin
      WB_ACK_O <= req;
      WB_DAT_O <= req ? rd : 32'h00000000;
      // enabled sources only, registered for a glitch-free pin
      IRQ <= |(status_q & enable_q & `HIELV_EN_WMASK); // R1 R18
      EVT_IRQ <= |(evt_sts_q & evt_en_q);
    end
  end

endmodule // hielv_top

// ===== verification/hielv_host.sv
`timescale 1ns/100ps
// host: one classic cycle per call, enable bits 11 and 5 and level bits 15:8 always sent as zero
module hielv_host (
  input wire clk,
  input wire ack,
  output logic cyc = 1'b0,
  output logic stb = 1'b0,
  output logic we = 1'b0,
  output logic [7:0] adr = 8'h0,
  output logic [31:0] dat = 32'h0
);
  task xfer(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr} <= {2'b11, w, a};
    dat <= a == 8'h5c ? d & 32'hfffff7df : a == 8'h68 ? d & 32'hffff00ff : d;
    do @(posedge clk); while (ack !== 1'b1);
    {cyc, stb, we, dat} <= {3'b0, ~dat};
  endtask
endmodule // hielv_host

// ===== verification/hielv_monitor.sv
`timescale 1ns/100ps
module hielv_mon (
  input wire SYS_CLK,
  input wire SYS_RST,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [31:0] WB_DAT_I,
  input wire [31:0] WB_DAT_O,
  input wire WB_ACK_O,
  input wire [31:0] SRC_EVENTS,
  input wire [7:0] TX_DATA_FREE,
  input wire IRQ
);
  // shadows of the enable mask and the tx data threshold, taken at the accepting edge
  wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire hit = WB_ADR_I == 8'h5c;
  reg [31:0] en_q;
  reg [7:0] thr_q;
  always @(posedge SYS_CLK) en_q <= SYS_RST ? 32'h0 : (req & WB_WE_I & hit ? WB_DAT_I : en_q);
  always @(posedge SYS_CLK)
    thr_q <= SYS_RST ? 8'h48 : (req & WB_WE_I & WB_ADR_I == 8'h68 ? WB_DAT_I[31:24] : thr_q);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
  ack_next_a: assert property (req |=> WB_ACK_O) else $error("no ack");
  idle_zero_a: assert property (!WB_ACK_O |-> WB_DAT_O == 0) else $error("idle data");
  en_read_a: assert property (
    WB_ACK_O & !WB_WE_I & hit |-> WB_DAT_O == (en_q & 32'hffbbfff8)) else $error("enable");
  masked_irq_a: assert property (!en_q && !$past(en_q) |-> !IRQ) else $error("irq");
  sw_irq_a: assert property ((en_q[31] && SRC_EVENTS[31]) [*3] |-> IRQ) else $error("sw");
  gpio_irq_a: assert property ((en_q[12] && SRC_EVENTS[12]) [*3] |-> IRQ) else $error("g");
  space_irq_a: assert property ((en_q[9] && TX_DATA_FREE > thr_q) [*3] |-> IRQ)
    else $error("s");
  cover property (IRQ && en_q[9]);
  cover property ($fell(IRQ));
  cover property (WB_ACK_O && !WB_WE_I);
endmodule // hielv_mon
bind hielv_top hielv_mon u_mon (.*);

// ===== verification/hielv_top_test.sv
`timescale 1ns/100ps
module hielv_top_test;
  logic clk = 0, rst = 1;
  logic [31:0] src = 0, v;
  logic [7:0] tdf = 0, lvl = 0;
  wire cyc, stb, we, ack, irq, eirq;
  wire [7:0] adr;
  wire [31:0] wd, rd;
  integer n_errors = 0, check_count = 0, seed = 6;
  logic [31:0] exp_q[$];
  always #5 clk = ~clk;
  hielv_host host (.clk(clk), .ack(ack), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat(wd));
  hielv_top DUT (.SYS_CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack),
    .SRC_EVENTS(src), .TX_DATA_FREE(tdf), .TX_STATUS_USED(lvl), .RX_STATUS_USED(lvl),
    .IRQ(irq), .EVT_IRQ(eirq));
  task chk(string n, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task rdc(logic [7:0] a, logic [31:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 32'h0);
  endtask
  task irqc(logic e);
    repeat (3) @(negedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge clk);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(negedge clk) if (ack === 1'b1 && we === 1'b0) chk("read", exp_q.pop_front(), rd);
  initial begin
    #30000;
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    rdc(8'h5c, 32'h0);
    rdc(8'h68, 32'h48000000);
    rdc(8'h40, 32'h0);
    v = $random(seed);
    host.xfer(1'b1, 8'h5c, v);
    rdc(8'h5c, v & 32'hffbbf7d8);
    v = $random(seed) & 32'h7f7fff7f;
    host.xfer(1'b1, 8'h68, v);
    rdc(8'h68, v & 32'hffff00ff);
    $display("register test done");
    host.xfer(1'b1, 8'h68, 32'h10000000);
    host.xfer(1'b1, 8'h58, 32'hffffffff);
    host.xfer(1'b1, 8'h5c, 32'h200);
    tdf <= 8'h11;
    irqc(1'b1);
    tdf <= 8'h10;
    host.xfer(1'b1, 8'h58, 32'h200);
    irqc(1'b0);
    src <= 32'h80001000;
    host.xfer(1'b1, 8'h5c, 32'h80000000);
    irqc(1'b1);
    host.xfer(1'b1, 8'h5c, 32'h0);
    irqc(1'b0);
    host.xfer(1'b1, 8'h5c, 32'h1288);
    {tdf, lvl} <= 16'hffff;
    irqc(1'b1);
    rdc(8'h58, 32'h80001288);
    host.xfer(1'b1, 8'h78, 32'h1);
    repeat (3) @(negedge clk);
    chk("evt_irq", 32'h1, {31'h0, eirq});
    host.xfer(1'b1, 8'h74, 32'h7);
    repeat (3) @(negedge clk);
    chk("evt_irq", 32'h0, {31'h0, eirq});
    $display("irq test done");
    end_sim;
  end
endmodule // hielv_top_test
